//--- hdl/ext_bus_dram_interface.sv
// Purpose: external bus cycles, byte write enables, strobe option, dram and refresh
// Assumes: one 20 MHz clock, cpu request held until o_bus_done
// Notes: register port is the internal block port, word wide
// Function
// RL1: upper space width taken from boot pin; 16-bit boot locks it
// RL2: upper write enable low only when high-byte-active and write both low
// RL3: lower write enable low only when address bit zero and write both low
// RL4: write enables launched with the address bus
// RL5: strobe option drives data strobe on shared pin, address and data held
// RL6: strobe cycles end only when the peripheral returns ready
// RL7: two dram banks, lower and upper space, each enabled separately
// RL8: any enabled bank turns on column strobes and address multiplexing
// RL9: software sets dram spaces to 16-bit width
// RL10: every refresh cycle lasts exactly seven clocks
// RL11: no refresh until the refresh unit is enabled
// RL12: refresh asserts column strobes before the row strobe
// RL13: dram access allows zero added wait states
// RL14: software picks dram wait states by memory speed
// RL15: control registers are 16-bit read/write words in a 256-byte block
// RL16: byte writes to the block still store the full 16-bit word
// RL17: software writes with byte writes, reads with word reads
// RL18: software makes no unaligned block accesses
// RL19: software leaves unused offsets alone
// RL20: width field 0 selects 16-bit, 1 selects 8-bit
// RL21: row strobe with full address, column with even bits on odd lines
// RL22: refresh drives all ones on the address
// RL23: ready input passes two flip-flops before use
// RL24: write enables stay high on read, refresh and idle
`timescale 1ns/10ps
`default_nettype none
module ext_bus_dram_interface
  import ext_bus_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_boot_width_pin,
  input wire logic i_async_ready_in,
  input wire logic i_bus_req,
  input wire logic i_bus_write,
  input wire logic [19:0] i_bus_addr,
  input wire logic i_bus_high_byte_active_n,
  input wire logic [15:0] i_bus_wdata,
  input wire logic [15:0] i_data_in,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  output logic o_bus_done,
  output logic [15:0] o_bus_rdata,
  output logic [15:0] o_reg_rdata,
  output logic [19:0] o_addr,
  output logic [15:0] o_data_out,
  output logic o_data_oe,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic o_high_byte_active_n,
  output logic o_upper_byte_write_en_n,
  output logic o_lower_byte_write_en_n,
  output logic o_data_strobe_n,
  output logic o_upper_region_select_n,
  output logic o_lower_region_select_n,
  output logic o_bank0_row_strobe_n,
  output logic o_bank1_row_strobe_n,
  output logic o_high_col_strobe_n,
  output logic o_low_col_strobe_n,
  output logic o_upper_width8
);
  import ext_bus_pkg::*;

  logic rst_n;
  logic ready_sync;
  logic boot_taken_reg;
  logic boot8_reg;
  logic [15:0] upper_ctrl_reg;
  logic [15:0] lower_ctrl_reg;
  logic [15:0] refresh_reg;
  logic [15:0] width_reg;
  logic [15:0] base_reg;
  logic [REF_IVL_W-1:0] ivl_cnt_reg;
  logic ref_pend_reg;
  bus_state_e state_reg;
  logic [3:0] cnt_reg;
  logic [19:0] col_addr;
  logic hit_upper;
  logic hit_lower;
  logic dram_hit;
  logic [CTRL_WS_W-1:0] req_ws;
  logic ref_start;

  // reset release and ready input both go through two flops
  sync2 u_rst_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_d(1'b1),
    .o_q(rst_n)
  );
  sync2 u_rdy_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(rst_n),
    .i_d(i_async_ready_in),
    .o_q(ready_sync) // [RL23]
  );

  // request decode: top nibble picks the region
  assign hit_upper = (i_bus_addr[19:16] == UPPER_NIBBLE);
  assign hit_lower = (i_bus_addr[19:16] == LOWER_NIBBLE);
  assign dram_hit = (hit_upper && upper_ctrl_reg[CTRL_DRAM_BIT]) ||
                    (hit_lower && lower_ctrl_reg[CTRL_DRAM_BIT]); // [RL7]
  assign req_ws = hit_upper ? upper_ctrl_reg[CTRL_WS_LSB +: CTRL_WS_W] :
                  lower_ctrl_reg[CTRL_WS_LSB +: CTRL_WS_W];
  assign ref_start = (state_reg == ST_IDLE) && ref_pend_reg;

  // column address: odd lines up to 17 take the even bit below them
  genvar gi;
  generate
    for (gi = 0; gi < 20; gi++) begin : g_col
      if ((gi % 2 == 1) && (gi <= 17)) begin : g_odd
        assign col_addr[gi] = o_addr[gi-1]; // [RL21]
      end else begin : g_keep
        assign col_addr[gi] = o_addr[gi];
      end
    end
  endgenerate

  // register block: word wide even for byte writes, odd offsets ignored
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      upper_ctrl_reg <= RST_CTRL;
      lower_ctrl_reg <= RST_CTRL;
      refresh_reg <= RST_REFRESH;
      width_reg <= RST_WIDTH;
      base_reg <= RST_BASE;
      boot_taken_reg <= 1'b0;
      boot8_reg <= 1'b0;
    end else begin
      // strap caught on the first clock after release
      if (!boot_taken_reg) begin
        boot_taken_reg <= 1'b1;
        width_reg[W_UPPER_BIT] <= i_boot_width_pin; // [RL1]
        boot8_reg <= i_boot_width_pin;
      end
      if (i_reg_wr && !i_reg_addr[0]) begin
        unique case (i_reg_addr)
          OFF_UPPER_CTRL: upper_ctrl_reg <= i_reg_wdata; // [RL16]
          OFF_LOWER_CTRL: lower_ctrl_reg <= i_reg_wdata;
          OFF_REFRESH_EN: refresh_reg <= i_reg_wdata;
          OFF_WIDTH_CFG: begin
            width_reg[W_IO_BIT] <= i_reg_wdata[W_IO_BIT]; // [RL20]
            width_reg[W_LOWER_BIT] <= i_reg_wdata[W_LOWER_BIT];
            width_reg[W_OTHER_BIT] <= i_reg_wdata[W_OTHER_BIT];
            width_reg[W_STROBE_BIT] <= i_reg_wdata[W_STROBE_BIT];
            // only an 8-bit boot leaves the upper width writable, both ways
            if (boot8_reg) begin
              width_reg[W_UPPER_BIT] <= i_reg_wdata[W_UPPER_BIT]; // [RL1]
            end
          end
          OFF_BLOCK_BASE: base_reg <= i_reg_wdata;
          default: ;
        endcase
      end
    end
  end

  // read port: unused offsets read zero
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_reg_rdata <= 16'h0000;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        OFF_UPPER_CTRL: o_reg_rdata <= upper_ctrl_reg; // [RL15]
        OFF_LOWER_CTRL: o_reg_rdata <= lower_ctrl_reg;
        OFF_REFRESH_EN: o_reg_rdata <= refresh_reg;
        OFF_WIDTH_CFG: o_reg_rdata <= {11'h000, width_reg[4:0]};
        OFF_BLOCK_BASE: o_reg_rdata <= base_reg;
        default: o_reg_rdata <= 16'h0000;
      endcase
    end
  end

  // refresh interval timer; a pending request survives until taken or until refresh is disabled
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ivl_cnt_reg <= '0;
      ref_pend_reg <= 1'b0;
    end else if (!refresh_reg[REF_EN_BIT]) begin
      ivl_cnt_reg <= refresh_reg[REF_IVL_W-1:0]; // [RL11]
      ref_pend_reg <= 1'b0;
    end else begin
      if (ivl_cnt_reg == '0) begin
        ivl_cnt_reg <= refresh_reg[REF_IVL_W-1:0];
        ref_pend_reg <= 1'b1; // set wins over the take below
      end else begin
        ivl_cnt_reg <= ivl_cnt_reg - 1'b1;
        if (ref_start) begin
          ref_pend_reg <= 1'b0;
        end
      end
    end
  end

  // bus cycle sequencer and every pin it launches
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
      o_bus_done <= 1'b0;
      o_bus_rdata <= 16'h0000;
      o_addr <= 20'h00000;
      o_data_out <= 16'h0000;
      o_data_oe <= 1'b0;
      o_rd_n <= 1'b1;
      o_wr_n <= 1'b1;
      o_high_byte_active_n <= 1'b1;
      o_upper_byte_write_en_n <= 1'b1;
      o_lower_byte_write_en_n <= 1'b1;
      o_data_strobe_n <= 1'b1;
      o_upper_region_select_n <= 1'b1;
      o_lower_region_select_n <= 1'b1;
      o_bank0_row_strobe_n <= 1'b1;
      o_bank1_row_strobe_n <= 1'b1;
      o_high_col_strobe_n <= 1'b1;
      o_low_col_strobe_n <= 1'b1;
      o_upper_width8 <= 1'b0;
    end else begin
      o_bus_done <= 1'b0;
      o_upper_width8 <= width_reg[W_UPPER_BIT];
      unique case (state_reg)
        ST_IDLE: begin
          if (ref_pend_reg) begin
            // refresh goes first so it never starves
            state_reg <= ST_REF;
            cnt_reg <= 4'h0;
            o_addr <= 20'hFFFFF; // [RL22]
            o_high_col_strobe_n <= 1'b0; // [RL12]
            o_low_col_strobe_n <= 1'b0;
          end else if (i_bus_req) begin
            o_addr <= i_bus_addr; // [RL4]
            o_rd_n <= i_bus_write;
            o_wr_n <= ~i_bus_write;
            o_high_byte_active_n <= i_bus_high_byte_active_n;
            o_upper_byte_write_en_n <= i_bus_high_byte_active_n | ~i_bus_write; // [RL2]
            o_lower_byte_write_en_n <= i_bus_addr[0] | ~i_bus_write; // [RL3]
            o_data_out <= i_bus_wdata;
            o_data_oe <= i_bus_write;
            o_upper_region_select_n <= ~hit_upper;
            o_lower_region_select_n <= ~hit_lower;
            cnt_reg <= {2'b00, req_ws};
            if (dram_hit) begin
              state_reg <= ST_RAS;
              o_bank0_row_strobe_n <= ~hit_lower;
              o_bank1_row_strobe_n <= ~hit_upper;
            end else if (width_reg[W_STROBE_BIT]) begin
              state_reg <= ST_STROBE;
              o_data_strobe_n <= 1'b0; // [RL5]
            end else begin
              state_reg <= ST_SRAM;
              o_data_strobe_n <= 1'b0; // shared pin acts as data enable
            end
          end
        end
        ST_SRAM: begin
          if (cnt_reg == 4'h0) begin
            state_reg <= ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        ST_STROBE: begin
          // no timeout: the peripheral must answer
          if (ready_sync) begin
            state_reg <= ST_IDLE; // [RL6]
          end
        end
        ST_RAS: begin
          state_reg <= ST_CAS;
          o_addr <= col_addr; // [RL8]
          o_high_col_strobe_n <= o_high_byte_active_n;
          o_low_col_strobe_n <= o_addr[0];
          cnt_reg <= cnt_reg + 4'(DRAM_CAS_CYC - 1); // [RL13]
        end
        ST_CAS: begin
          if (cnt_reg == 4'h0) begin
            state_reg <= ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        ST_REF: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == REF_RAS_ON) begin
            o_bank0_row_strobe_n <= 1'b0;
            o_bank1_row_strobe_n <= 1'b0;
          end else if (cnt_reg == REF_RAS_OFF) begin
            o_bank0_row_strobe_n <= 1'b1;
            o_bank1_row_strobe_n <= 1'b1;
            o_high_col_strobe_n <= 1'b1;
            o_low_col_strobe_n <= 1'b1;
          end else if (cnt_reg == REF_CYC - 4'h1) begin
            state_reg <= ST_IDLE; // [RL10]
          end
        end
      endcase
      // common cycle end: release every strobe and enable
      if (((state_reg == ST_SRAM || state_reg == ST_CAS) && cnt_reg == 4'h0) ||
          (state_reg == ST_STROBE && ready_sync)) begin
        o_bus_done <= 1'b1;
        if (o_wr_n) begin
          o_bus_rdata <= i_data_in;
        end
        o_rd_n <= 1'b1;
        o_wr_n <= 1'b1;
        o_upper_byte_write_en_n <= 1'b1; // [RL24]
        o_lower_byte_write_en_n <= 1'b1;
        o_data_oe <= 1'b0;
        o_data_strobe_n <= 1'b1;
        o_upper_region_select_n <= 1'b1;
        o_lower_region_select_n <= 1'b1;
        o_bank0_row_strobe_n <= 1'b1;
        o_bank1_row_strobe_n <= 1'b1;
        o_high_col_strobe_n <= 1'b1;
        o_low_col_strobe_n <= 1'b1;
      end
    end
  end

  // checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!rst_n);

  a_upper_we_form: assert property (!o_upper_byte_write_en_n |->
    (!o_high_byte_active_n && !o_wr_n)) else $error("upper write enable bad"); // [RL2]
  a_lower_we_form: assert property (!o_lower_byte_write_en_n |->
    (!o_addr[0] && !o_wr_n)) else $error("lower write enable bad"); // [RL3]
  a_we_idle_high: assert property ((state_reg == ST_IDLE || state_reg == ST_REF) |->
    (o_upper_byte_write_en_n && o_lower_byte_write_en_n)) else $error("write enable idle"); // [RL24]
  a_ref_seven: assert property ($rose(state_reg == ST_REF) |->
    (state_reg == ST_REF) [*7] ##1 (state_reg != ST_REF)) else $error("refresh length"); // [RL10]
  a_ref_cas_first: assert property ($fell(o_bank0_row_strobe_n) && state_reg == ST_REF |->
    !o_high_col_strobe_n && !o_low_col_strobe_n && !$past(o_low_col_strobe_n))
    else $error("ras before cas"); // [RL12]
  a_ref_needs_en: assert property ($rose(state_reg == ST_REF) |->
    $past(refresh_reg[REF_EN_BIT], 2)) else $error("refresh while off"); // [RL11]
  a_ref_addr_ones: assert property (state_reg == ST_REF |-> o_addr == 20'hFFFFF)
    else $error("refresh address"); // [RL22]
  a_strobe_ready: assert property (state_reg == ST_STROBE && !ready_sync |=>
    state_reg == ST_STROBE && !o_data_strobe_n) else $error("strobe ended early"); // [RL6]
  a_strobe_addr_hold: assert property (state_reg == ST_STROBE |=> $stable(o_addr))
    else $error("address moved under strobe"); // [RL5]
  a_col_mux: assert property (state_reg == ST_RAS |=> o_addr[1] == $past(o_addr[0]))
    else $error("column address"); // [RL21]
  a_boot16_lock: assert property (boot_taken_reg && !boot8_reg |=>
    !width_reg[W_UPPER_BIT]) else $error("16-bit boot changed"); // [RL1]
  a_dram_only_en: assert property ($rose(state_reg == ST_RAS) |->
    $past(upper_ctrl_reg[CTRL_DRAM_BIT]) || $past(lower_ctrl_reg[CTRL_DRAM_BIT]))
    else $error("dram cycle without bank"); // [RL8]

  c_refresh: cover property ($rose(state_reg == ST_REF));
  c_dram_write: cover property (state_reg == ST_CAS && !o_wr_n);
  c_strobe_end: cover property (state_reg == ST_STROBE ##1 o_bus_done);
  c_sram_read: cover property (state_reg == ST_SRAM && !o_rd_n ##1 o_bus_done);
endmodule
`default_nettype wire

//--- hdl/ext_bus_pkg.sv
// Purpose: shared constants and types for the external bus and dram interface
// Assumes: 16-bit register words, 8-bit offsets inside the register block
// Notes: field positions below the documented offsets are local choices
package ext_bus_pkg;
  // register block offsets
  localparam logic [7:0] OFF_UPPER_CTRL = 8'hA0;
  localparam logic [7:0] OFF_LOWER_CTRL = 8'hA2;
  localparam logic [7:0] OFF_REFRESH_EN = 8'hE4;
  localparam logic [7:0] OFF_WIDTH_CFG = 8'hF2;
  localparam logic [7:0] OFF_BLOCK_BASE = 8'hFE;
  // region control fields
  localparam int CTRL_WS_LSB = 0;
  localparam int CTRL_WS_W = 2;
  localparam int CTRL_DRAM_BIT = 6;
  // refresh unit fields
  localparam int REF_EN_BIT = 15;
  localparam int REF_IVL_W = 9;
  // width config fields, 0 = 16-bit, 1 = 8-bit
  localparam int W_IO_BIT = 0;
  localparam int W_LOWER_BIT = 1;
  localparam int W_UPPER_BIT = 2;
  localparam int W_OTHER_BIT = 3;
  localparam int W_STROBE_BIT = 4;
  // values after reset
  localparam logic [15:0] RST_CTRL = 16'h0003;
  localparam logic [15:0] RST_REFRESH = 16'h0000;
  localparam logic [15:0] RST_WIDTH = 16'h0000;
  localparam logic [15:0] RST_BASE = 16'h00FF;
  // region decode on the top address nibble
  localparam logic [3:0] UPPER_NIBBLE = 4'hF;
  localparam logic [3:0] LOWER_NIBBLE = 4'h0;
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int DRAM_ACCESS_NS = 50;
  localparam int DRAM_CAS_CYC = (DRAM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] REF_CYC = 4'h7;
  localparam logic [3:0] REF_RAS_ON = 4'h1;
  localparam logic [3:0] REF_RAS_OFF = 4'h5;
  typedef enum logic [2:0] {ST_IDLE, ST_SRAM, ST_STROBE, ST_RAS, ST_CAS, ST_REF} bus_state_e;
endpackage

//--- hdl/sync2.sv
// Purpose: two-stage level synchroniser with asynchronous clear
// Assumes: i_d may change at any time relative to i_ref_clk
// Notes: the first stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module sync2 (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_d,
  output logic o_q
);
  logic meta_reg;
  // both stages clear to a constant under reset
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= 1'b0;
      o_q <= 1'b0;
    end else begin
      meta_reg <= i_d;
      o_q <= meta_reg;
    end
  end
endmodule
`default_nettype wire

//--- sim/ext_bus_dram_interface_tb_top.sv
// Purpose: self-checking bench for the external bus and dram block
// Assumes: partner model stands in for memory and strobe peripherals
// Notes: random data from a fixed seed; boot width is exercised last, after refresh
`timescale 1ns/10ps
`default_nettype none
module ext_bus_dram_interface_tb_top;
  import ext_bus_pkg::*;
  logic clk, rst_n, boot, rdy, req, wr, hb_n, rwr, rrd, smode, done, oe, rd_n, wr_n, hba_n;
  logic uwe_n, lwe_n, strb_n, up_sel_n, lo_sel_n, row0_n, row1_n, colh_n, coll_n, up8, rl;
  logic [19:0] addr, a_pin, a;
  logic [15:0] wd, din, brd, rrdat, dout, rwd, v, exp;
  logic [15:0] sh [16];
  logic [7:0] radr;
  logic [3:0] dly;
  int errors, compares, n;
  logic [7:0] offs [5] = '{OFF_UPPER_CTRL, OFF_LOWER_CTRL, OFF_REFRESH_EN, OFF_WIDTH_CFG,
    OFF_BLOCK_BASE};
  logic [15:0] rsts [5] = '{RST_CTRL, RST_CTRL, RST_REFRESH, RST_WIDTH, RST_BASE};
  ext_bus_dram_interface u_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_boot_width_pin(boot),
    .i_async_ready_in(rdy), .i_bus_req(req), .i_bus_write(wr), .i_bus_addr(addr),
    .i_bus_high_byte_active_n(hb_n), .i_bus_wdata(wd), .i_data_in(din), .i_reg_wr(rwr),
    .i_reg_rd(rrd), .i_reg_addr(radr), .i_reg_wdata(rwd), .o_bus_done(done),
    .o_bus_rdata(brd), .o_reg_rdata(rrdat), .o_addr(a_pin), .o_data_out(dout),
    .o_data_oe(oe), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_high_byte_active_n(hba_n),
    .o_upper_byte_write_en_n(uwe_n), .o_lower_byte_write_en_n(lwe_n),
    .o_data_strobe_n(strb_n), .o_upper_region_select_n(up_sel_n),
    .o_lower_region_select_n(lo_sel_n), .o_bank0_row_strobe_n(row0_n),
    .o_bank1_row_strobe_n(row1_n), .o_high_col_strobe_n(colh_n),
    .o_low_col_strobe_n(coll_n), .o_upper_width8(up8));
  ext_bus_partner u_far (.i_ref_clk(clk), .i_addr(a_pin), .i_data(dout), .i_rd_n(rd_n),
    .i_upper_we_n(uwe_n), .i_lower_we_n(lwe_n), .i_strobe_n(strb_n), .i_strobe_mode(smode),
    .i_ready_dly(dly), .o_data(din), .o_ready(rdy));
  // free-running reference clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic check(input logic [19:0] seen, input logic [19:0] want);
    compares++;
    if (seen !== want) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // column address: even bits copied onto the odd lines below bit 18
  function automatic logic [19:0] colmux(input logic [19:0] x);
    colmux = x;
    for (int i = 0; i < 9; i++) colmux[2*i+1] = x[2*i];
  endfunction
  task automatic do_reset(input logic b);
    rst_n = 1'b0;
    boot = b;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask
  task automatic reg_write(input logic [7:0] ad, input logic [15:0] d);
    rwr = 1'b1;
    radr = ad;
    rwd = d;
    @(negedge clk);
    rwr = 1'b0;
    @(negedge clk);
  endtask
  task automatic reg_read(input logic [7:0] ad, output logic [15:0] d);
    rrd = 1'b1;
    radr = ad;
    @(negedge clk);
    rrd = 1'b0;
    d = rrdat;
    @(negedge clk);
  endtask
  // one bus cycle, request held until done is seen; pins checked each active cycle
  task automatic bus_cycle(input logic w, input logic [19:0] ad, input logic hb,
                           input logic [15:0] d, input logic dram, output int cyc);
    logic row_n, oth_n;
    int act;
    act = 0;
    cyc = 0;
    req = 1'b1;
    wr = w;
    addr = ad;
    hb_n = hb;
    wd = d;
    while (done !== 1'b1 && cyc < 200) begin
      @(negedge clk);
      cyc++;
      row_n = (ad[19:16] == UPPER_NIBBLE) ? row1_n : row0_n;
      oth_n = (ad[19:16] == UPPER_NIBBLE) ? row0_n : row1_n;
      if (done !== 1'b1 && (rd_n === 1'b0 || wr_n === 1'b0)) begin
        act++;
        if (!dram) check(a_pin, ad);
        if (smode) check(strb_n, 1'b0);
        check(uwe_n, hb | !w);
        check(lwe_n, ad[0] | !w);
        if (dram && row_n === 1'b0 && colh_n === 1'b1) check(a_pin, ad);
        if (dram && colh_n === 1'b0) check(a_pin, colmux(ad));
        if (dram) check(oth_n, 1'b1);
        check(up_sel_n, ad[19:16] != UPPER_NIBBLE);
        check(lo_sel_n, ad[19:16] != LOWER_NIBBLE);
        check({oe, rd_n, wr_n, hba_n}, {w, w, !w, hb});
      end
    end
    if (cyc >= 200) begin
      errors++;
      report_and_stop();
    end
    check(act > 0, 1'b1);
    req = 1'b0;
    // one idle edge so the done pulse is gone before the next call
    @(negedge clk);
  endtask
  initial begin
    {rst_n, boot, req, wr, hb_n, rwr, rrd, smode, addr, wd, radr, rwd} = '0;
    dly = 4'h2;
    errors = 0;
    compares = 0;
    n = $urandom(13107);
    for (int i = 0; i < 16; i++) sh[i] = 16'h0000;
    @(negedge clk);
    do_reset(1'b0);
    // reset values, full-word write and read-back, odd offset dropped
    for (int i = 0; i < 5; i++) begin
      reg_read(offs[i], v);
      check(v, rsts[i]);
      exp = 16'($urandom) | 16'h0004;
      reg_write(offs[i], exp);
      reg_write(offs[i] + 8'h01, ~exp);
      reg_read(offs[i], v);
      if (offs[i] == OFF_WIDTH_CFG) exp = exp & 16'h001B;
      check(v, exp);
      check(up8, 1'b0);
      reg_write(offs[i], rsts[i]);
    end
    reg_write(8'h50, 16'hFFFF);
    reg_read(8'h50, v);
    check(v, 16'h0000);
    $display("test registers done");
    // static cycles: lower space no waits, upper keeps three
    reg_write(OFF_LOWER_CTRL, 16'h0000);
    for (int i = 0; i < 12; i++) begin
      a = {(i % 2) ? UPPER_NIBBLE : LOWER_NIBBLE, 16'($urandom)};
      exp = 16'($urandom);
      rl = (i < 2) ? 1'b1 : 1'($urandom);
      bus_cycle(1'b1, a, rl, exp, 1'b0, n);
      check(n, (i % 2) ? 5 : 2);
      if (!rl) sh[a[4:1]][15:8] = exp[15:8];
      if (!a[0]) sh[a[4:1]][7:0] = exp[7:0];
      bus_cycle(1'b0, a & 20'hFFFFE, 1'b0, 16'h0000, 1'b0, n);
      check(brd, sh[a[4:1]]);
    end
    $display("test static cycles done");
    // strobe option, prompt and slow peripheral
    reg_write(OFF_WIDTH_CFG, 16'h0010);
    smode = 1'b1;
    for (int i = 0; i < 2; i++) begin
      dly = i ? 4'h9 : 4'h0;
      a = {4'h5, 12'($urandom), 4'h2};
      exp = 16'($urandom);
      bus_cycle(1'b1, a, 1'b0, exp, 1'b0, n);
      check(n >= dly + 3 && n <= dly + 8, 1'b1);
      bus_cycle(1'b0, a, 1'b0, 16'h0000, 1'b0, n);
      check(brd, exp);
    end
    smode = 1'b0;
    reg_write(OFF_WIDTH_CFG, RST_WIDTH);
    $display("test strobe done");
    // both dram banks, full-width spaces, no added waits
    reg_write(OFF_LOWER_CTRL, 16'h0040);
    reg_write(OFF_UPPER_CTRL, 16'h0040);
    for (int i = 0; i < 4; i++) begin
      a = {(i % 2) ? UPPER_NIBBLE : LOWER_NIBBLE, 15'($urandom), 1'b0};
      bus_cycle(i[1], a, 1'b0, 16'($urandom), 1'b1, n);
      check(n, 3);
    end
    $display("test dram done");
    // refresh stays off until enabled, then column strobes lead the rows
    n = 0;
    repeat (300) begin
      @(negedge clk);
      if (colh_n !== 1'b1 || coll_n !== 1'b1) n++;
    end
    check(n, 0);
    reg_write(OFF_REFRESH_EN, 16'h8014);
    repeat (2) begin
      n = 0;
      while (colh_n !== 1'b0 && n < 1000) begin
        @(negedge clk);
        n++;
      end
      if (n >= 1000) begin
        errors++;
        report_and_stop();
      end
      check({row0_n, row1_n, coll_n}, 3'b110);
      check(a_pin, 20'hFFFFF);
      n = 0;
      rl = 1'b0;
      while (colh_n === 1'b0 && n < 20) begin
        check({uwe_n, lwe_n}, 2'b11);
        if (row0_n === 1'b0 && row1_n === 1'b0) rl = 1'b1;
        n++;
        @(negedge clk);
      end
      check(n, REF_CYC - 1);
      check(rl, 1'b1);
    end
    reg_write(OFF_REFRESH_EN, RST_REFRESH);
    $display("test refresh done");
    // eight-bit boot leaves the upper width writable
    do_reset(1'b1);
    check(up8, 1'b1);
    reg_write(OFF_WIDTH_CFG, 16'h0000);
    @(negedge clk);
    check(up8, 1'b0);
    reg_write(OFF_WIDTH_CFG, 16'h0004);
    @(negedge clk);
    check(up8, 1'b1);
    $display("test boot width done");
    report_and_stop();
  end
endmodule
`default_nettype wire

//--- sim/ext_bus_partner.sv
// Purpose: far-side model of static memory and strobe peripherals
// Assumes: sixteen words decoded on address bits 4..1
// Notes: ready delay is set by the bench to act prompt or slow
`timescale 1ns/10ps
`default_nettype none
module ext_bus_partner (
  input wire logic i_ref_clk,
  input wire logic [19:0] i_addr,
  input wire logic [15:0] i_data,
  input wire logic i_rd_n,
  input wire logic i_upper_we_n,
  input wire logic i_lower_we_n,
  input wire logic i_strobe_n,
  input wire logic i_strobe_mode,
  input wire logic [3:0] i_ready_dly,
  output logic [15:0] o_data,
  output logic o_ready
);
  logic [15:0] mem [16];
  logic [15:0] flip;
  logic [3:0] cnt;
  initial begin
    flip = 16'hA5A5;
    cnt = 4'h0;
    o_ready = 1'b0;
    for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
  end
  // each byte lane latched only by its own enable
  always @(posedge i_ref_clk) begin
    flip <= ~flip;
    if (!i_upper_we_n) mem[i_addr[4:1]][15:8] <= i_data[15:8];
    if (!i_lower_we_n) mem[i_addr[4:1]][7:0] <= i_data[7:0];
  end
  // released bus toggles so a late sample never looks right
  assign o_data = i_rd_n ? flip : mem[i_addr[4:1]];
  // ready moves on the falling edge, unrelated to the sampling edge
  always @(negedge i_ref_clk) begin
    if (!i_strobe_mode || i_strobe_n) begin
      cnt <= 4'h0;
      o_ready <= 1'b0;
    end else if (cnt == i_ready_dly) o_ready <= 1'b1;
    else cnt <= cnt + 4'h1;
  end
endmodule
`default_nettype wire
